// ==== design/toca_pkg.sv ====
package toca_pkg;

	// operating mode field codes
	typedef enum logic [1:0] {
		TOCA_MODE_COMPARE = 2'b00,  // compare match output
		TOCA_MODE_CAPTURE = 2'b01,  // capture input
		TOCA_MODE_PWM     = 2'b10,  // pwm or single pulse
		TOCA_MODE_TIMER   = 2'b11   // timer/counter, pin unused
	} toca_mode_type;

	// output function codes, compare match output mode
	localparam logic [1:0] TOCA_CMP_NONE   = 2'b00;  // no change on match
	localparam logic [1:0] TOCA_CMP_LOW    = 2'b01;  // go low on match
	localparam logic [1:0] TOCA_CMP_HIGH   = 2'b10;  // go high on match
	localparam logic [1:0] TOCA_CMP_TOGGLE = 2'b11;  // toggle on match

	// output function codes, pwm mode
	localparam logic [1:0] TOCA_PWM_INACTIVE = 2'b00;  // forced inactive
	localparam logic [1:0] TOCA_PWM_ACTIVE   = 2'b01;  // forced active
	localparam logic [1:0] TOCA_PWM_WAVE     = 2'b10;  // pwm waveform
	localparam logic [1:0] TOCA_PWM_PULSE    = 2'b11;  // single pulse

	// register byte addresses
	localparam logic [11:0] TOCA_ADDR_CONTROL   = 12'h000;
	localparam logic [11:0] TOCA_ADDR_CNT_LOW   = 12'h004;
	localparam logic [11:0] TOCA_ADDR_CNT_HIGH  = 12'h008;
	localparam logic [11:0] TOCA_ADDR_CMPA_LOW  = 12'h00C;
	localparam logic [11:0] TOCA_ADDR_CMPA_HIGH = 12'h010;
	localparam logic [11:0] TOCA_ADDR_CMPP      = 12'h014;

	// control register field positions
	localparam int TOCA_CTL_CLEAR_SEL = 0;  // counter_clear_select
	localparam int TOCA_CTL_SWAP      = 1;  // period_duty_swap
	localparam int TOCA_CTL_POLARITY  = 2;  // output_polarity_invert
	localparam int TOCA_CTL_LEVEL     = 3;  // output_level_control
	localparam int TOCA_CTL_FUNC_LO   = 4;  // output function, low bit
	localparam int TOCA_CTL_FUNC_HI   = 5;  // output function, high bit
	localparam int TOCA_CTL_MODE_LO   = 6;  // mode_select_low
	localparam int TOCA_CTL_MODE_HI   = 7;  // mode_select_high
	localparam int TOCA_CTL_RUN       = 8;  // counter run enable

	// reset values
	localparam logic [8:0]  TOCA_CONTROL_RESET = 9'h000;
	localparam logic [15:0] TOCA_CMPA_RESET    = 16'h0000;
	localparam logic [7:0]  TOCA_CMPP_RESET    = 8'h00;
	localparam logic [15:0] TOCA_COUNT_RESET   = 16'h0000;

endpackage : toca_pkg

// ==== design/toca_counter.sv ====
`timescale 1ns/1ps
module toca_counter
	import toca_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        run,
	input  wire logic        clear,
	output logic      [15:0] count
);

	// free running 16-bit up counter, held at zero while stopped
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= TOCA_COUNT_RESET;
		end else if (clk_en) begin
			if (!run || clear) begin
				// stopped or a selected match: restart from zero
				count <= TOCA_COUNT_RESET;
			end else begin
				// natural wrap from ffff to 0000 is the overflow
				count <= count + 16'h0001;
			end
		end
	end

endmodule : toca_counter

// ==== design/toca_output.sv ====
`timescale 1ns/1ps
module toca_output
	import toca_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          reset,
	input  wire logic          clk_en,
	input  wire toca_mode_type mode,
	input  wire logic    [1:0] func,
	input  wire logic          level,
	input  wire logic          polarity,
	input  wire logic          start,
	input  wire logic          a_match,
	input  wire logic          duty_active,
	output logic               pin,
	output logic               pin_oe
);

	logic cmp_level;     // held pin level in compare match output mode
	logic pulse_active;  // single pulse still running
	logic next_raw;      // level before the polarity stage

	// compare mode level: initial value on start, changed by comparator a only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cmp_level <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				cmp_level <= level;
			end else if (a_match) begin
				// comparator p never reaches here
				case (func)
					TOCA_CMP_LOW:    cmp_level <= 1'b0;
					TOCA_CMP_HIGH:   cmp_level <= 1'b1;
					TOCA_CMP_TOGGLE: cmp_level <= ~cmp_level;
					default:         cmp_level <= cmp_level;
				endcase
			end
		end
	end

	// single pulse: active from start until the comparator a match
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pulse_active <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				pulse_active <= 1'b1;
			end else if (a_match) begin
				pulse_active <= 1'b0;
			end
		end
	end

	// mode logic: active level in pwm is the level setting
	always_comb begin
		next_raw = 1'b0;
		case (mode)
			TOCA_MODE_COMPARE: next_raw = cmp_level;
			TOCA_MODE_PWM: begin
				case (func)
					TOCA_PWM_ACTIVE: next_raw = level;
					TOCA_PWM_WAVE:   next_raw = duty_active ? level : ~level;
					TOCA_PWM_PULSE:  next_raw = pulse_active ? level : ~level;
					default:         next_raw = ~level;
				endcase
			end
			// timer/counter and capture leave the level unused
			default: next_raw = 1'b0;
		endcase
	end

	// polarity is the last stage before the pin, not applied in timer mode
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin <= 1'b0;
		end else if (clk_en) begin
			if (mode == TOCA_MODE_TIMER) begin
				pin <= 1'b0;
			end else begin
				pin <= next_raw ^ polarity;
			end
		end
	end

	// pin driven only in the two output modes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_oe <= 1'b0;
		end else if (clk_en) begin
			pin_oe <= (mode == TOCA_MODE_COMPARE) || (mode == TOCA_MODE_PWM);
		end
	end

endmodule : toca_output

// ==== design/toca_top.sv ====
// Functional notes
// - compare mode: level setting gives initial pin level
// - pwm/pulse: level setting gives active level
// - level setting ignored in timer/counter mode
// - polarity bit inverts pin, not in timer
// - swap bit exchanges period and duty registers for pwm waveform; single pulse still ends on comparator a
// - clear select 1: clear on comparator a
// - clear select 0: clear on p or overflow
// - overflow clear only when register p zero
// - clear select only used in compare/timer modes
// - counter low byte readable, read only, zero reset
// - counter high byte readable, read only, zero reset
// - compare a low byte read-write, zero reset
// - compare a high byte read-write, zero reset
// - two-bit mode field: 00, 10, 11 decoded
// - register p compared with counter high byte
// - compare mode pin changes only on a match, a run start or a write of the polarity bit
`timescale 1ns/1ps
module toca_top
	import toca_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic  [3:0] pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             timer_output_pin,
	output logic             timer_output_oe
);

	// last count of a period of p x 256 clocks; p of zero wraps to ffff
	function automatic logic [15:0] toca_p_end(input logic [7:0] p);
		logic [7:0] high;
		high = p - 8'h01;
		toca_p_end = {high, 8'hFF};
	endfunction : toca_p_end

	// true while the counter lies below a duty boundary
	function automatic logic toca_below(input logic [15:0] cnt, input logic [15:0] bound);
		toca_below = cnt < bound;
	endfunction : toca_below

	// true for an address that holds a register
	function automatic logic toca_mapped(input logic [11:0] addr);
		toca_mapped = (addr == TOCA_ADDR_CONTROL)   || (addr == TOCA_ADDR_CNT_LOW) ||
		              (addr == TOCA_ADDR_CNT_HIGH)  || (addr == TOCA_ADDR_CMPA_LOW) ||
		              (addr == TOCA_ADDR_CMPA_HIGH) || (addr == TOCA_ADDR_CMPP);
	endfunction : toca_mapped

	// control register fields
	toca_mode_type      mode_select;              // mode_select_high:mode_select_low
	logic         [1:0] output_function;          // output function select
	logic               output_level_control;     // initial or active level
	logic               output_polarity_invert;   // final inversion
	logic               period_duty_swap;         // pwm role swap
	logic               counter_clear_select;     // clear source select
	logic               counter_run;              // counter enable

	// compare registers
	logic        [15:0] compare_register_a;       // 16-bit comparator a value
	logic         [7:0] compare_register_p;       // 8-bit comparator p value

	// timer datapath
	logic        [15:0] count;                    // live counter value
	logic               run_q;                    // run enable one clock ago
	logic               run_start;                // run enable rising edge
	logic               a_match;                  // comparator a hit
	logic               p_match;                  // comparator p hit or overflow
	logic               counter_clear;            // selected clear source
	logic               duty_active;              // pwm in active phase
	logic         [8:0] control_view;             // control register read view

	// bus strobes
	logic               bus_write;                // write takes effect this edge
	logic               bus_setup;                // setup phase of any transfer
	logic               access_error;             // latched decode failure

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------

	// access phase is always one cycle long
	assign pready    = psel && penable;
	assign pslverr   = pready && access_error;
	assign bus_write = psel && penable && pwrite && !access_error && clk_en;
	assign bus_setup = psel && !penable;

	// decode error caught in the setup phase, answered in the access phase
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			access_error <= 1'b0;
		end else if (clk_en && bus_setup) begin
			access_error <= !toca_mapped(paddr);
		end
	end

	// control bits gathered in one view for read back
	assign control_view = {counter_run, mode_select, output_function, output_level_control,
	                       output_polarity_invert, period_duty_swap, counter_clear_select};

	// read data captured at setup so it is steady through the access phase
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (clk_en && bus_setup) begin
			if (pwrite) begin
				prdata <= 32'h00000000;
			end else if (paddr == TOCA_ADDR_CONTROL) begin
				prdata <= {23'h000000, control_view};
			end else if (paddr == TOCA_ADDR_CNT_LOW) begin
				prdata <= {24'h000000, count[7:0]};
			end else if (paddr == TOCA_ADDR_CNT_HIGH) begin
				prdata <= {24'h000000, count[15:8]};
			end else if (paddr == TOCA_ADDR_CMPA_LOW) begin
				prdata <= {24'h000000, compare_register_a[7:0]};
			end else if (paddr == TOCA_ADDR_CMPA_HIGH) begin
				prdata <= {24'h000000, compare_register_a[15:8]};
			end else if (paddr == TOCA_ADDR_CMPP) begin
				prdata <= {24'h000000, compare_register_p};
			end else begin
				prdata <= 32'h00000000;  // unmapped reads as zero with an error
			end
		end
	end

	// control register: lane 0 holds the mode and output bits, lane 1 the run bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode_select            <= toca_mode_type'(TOCA_CONTROL_RESET[TOCA_CTL_MODE_HI:TOCA_CTL_MODE_LO]);
			output_function        <= TOCA_CONTROL_RESET[TOCA_CTL_FUNC_HI:TOCA_CTL_FUNC_LO];
			output_level_control   <= TOCA_CONTROL_RESET[TOCA_CTL_LEVEL];
			output_polarity_invert <= TOCA_CONTROL_RESET[TOCA_CTL_POLARITY];
			period_duty_swap       <= TOCA_CONTROL_RESET[TOCA_CTL_SWAP];
			counter_clear_select   <= TOCA_CONTROL_RESET[TOCA_CTL_CLEAR_SEL];
			counter_run            <= TOCA_CONTROL_RESET[TOCA_CTL_RUN];
		end else if (bus_write && paddr == TOCA_ADDR_CONTROL) begin
			if (pstrb[0]) begin
				// mode field decoded as a two-bit code
				mode_select            <= toca_mode_type'(pwdata[TOCA_CTL_MODE_HI:TOCA_CTL_MODE_LO]);
				output_function        <= pwdata[TOCA_CTL_FUNC_HI:TOCA_CTL_FUNC_LO];
				output_level_control   <= pwdata[TOCA_CTL_LEVEL];
				output_polarity_invert <= pwdata[TOCA_CTL_POLARITY];
				period_duty_swap       <= pwdata[TOCA_CTL_SWAP];
				counter_clear_select   <= pwdata[TOCA_CTL_CLEAR_SEL];
			end
			if (pstrb[1]) begin
				counter_run <= pwdata[TOCA_CTL_RUN];
			end
		end
	end

	// compare register a, one byte per register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			compare_register_a <= TOCA_CMPA_RESET;
		end else if (bus_write && pstrb[0]) begin
			if (paddr == TOCA_ADDR_CMPA_LOW) begin
				compare_register_a[7:0] <= pwdata[7:0];
			end else if (paddr == TOCA_ADDR_CMPA_HIGH) begin
				compare_register_a[15:8] <= pwdata[7:0];
			end
		end
	end

	// compare register p
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			compare_register_p <= TOCA_CMPP_RESET;
		end else if (bus_write && pstrb[0] && paddr == TOCA_ADDR_CMPP) begin
			compare_register_p <= pwdata[7:0];
		end
	end

	// counter registers take no writes: a write there is simply dropped

	// ---------------------------------------------------------------
	// comparators and clear selection
	// ---------------------------------------------------------------

	// run edge restarts the output logic
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			run_q <= 1'b0;
		end else if (clk_en) begin
			run_q <= counter_run;
		end
	end

	assign run_start = counter_run && !run_q;

	// comparator a watches all sixteen counter bits
	assign a_match = counter_run && (count == compare_register_a);

	// comparator p sees only the high byte, so periods are 256-clock multiples;
	// with p at zero the end is ffff, which is the overflow
	assign p_match = counter_run && (count == toca_p_end(compare_register_p));

	// clear source per mode
	always_comb begin
		counter_clear = 1'b0;
		case (mode_select)
			TOCA_MODE_COMPARE, TOCA_MODE_TIMER: begin
				if (counter_clear_select) begin
					counter_clear = a_match;
				end else begin
					counter_clear = p_match;
				end
			end
			TOCA_MODE_PWM: begin
				// clear select ignored, period register clears
				counter_clear = period_duty_swap ? a_match : p_match;
			end
			default: begin
				// capture: clear select ignored, comparator p or overflow clears
				counter_clear = p_match;
			end
		endcase
	end

	// duty phase: below the duty register, which the swap bit picks
	always_comb begin
		duty_active = 1'b0;
		if (!period_duty_swap) begin
			duty_active = toca_below(count, compare_register_a);
		end else if (compare_register_p == 8'h00) begin
			duty_active = 1'b1;  // p of zero means a 65536-clock duty
		end else begin
			duty_active = toca_below(count, {compare_register_p, 8'h00});
		end
	end

	// ---------------------------------------------------------------
	// counter and output stage
	// ---------------------------------------------------------------

	toca_counter u_counter (
		.clk_sys (clk_sys),
		.reset   (reset),
		.clk_en  (clk_en),
		.run     (counter_run),
		.clear   (counter_clear),
		.count   (count)
	);

	toca_output u_output (
		.clk_sys     (clk_sys),
		.reset       (reset),
		.clk_en      (clk_en),
		.mode        (mode_select),
		.func        (output_function),
		.level       (output_level_control),
		.polarity    (output_polarity_invert),
		.start       (run_start),
		.a_match     (a_match),
		.duty_active (duty_active),
		.pin         (timer_output_pin),
		.pin_oe      (timer_output_oe)
	);

endmodule : toca_top

// ==== test/toca_pin_load.sv ====
`timescale 1ns/1ps
// far side of the timer pin: a load with a weak pull-down
module toca_pin_load (
	input  wire logic pin,
	input  wire logic oe,
	output logic      line_level
);
	// released pin is pulled low, so a stale level never shows
	assign line_level = oe ? pin : 1'b0;
endmodule : toca_pin_load

// ==== test/toca_top_props.sv ====
`timescale 1ns/1ps
module toca_top_props
	import toca_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic  [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_oe
);
	logic [8:0]  sh_ctl; // shadow of the control register
	logic [15:0] sh_a;   // shadow of compare register a
	logic        wr_acc; // write access edge
	logic        acc;    // any access cycle
	logic        en_q;   // clock enable one edge ago
	assign wr_acc = psel && penable && pwrite && clk_en;
	assign acc = psel && penable && en_q;
	// clock enable delayed by one edge, qualifies the access phase
	always_ff @(posedge clk_sys) begin
		en_q <= clk_en;
	end
	// follow control and compare a writes as the bus sees them; lane 1 holds the run bit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sh_ctl <= TOCA_CONTROL_RESET;
			sh_a <= TOCA_CMPA_RESET;
		end else if (wr_acc) begin
			if (pstrb[0] && paddr == TOCA_ADDR_CONTROL) sh_ctl[7:0] <= pwdata[7:0];
			if (pstrb[1] && paddr == TOCA_ADDR_CONTROL) sh_ctl[8] <= pwdata[8];
			if (pstrb[0] && paddr == TOCA_ADDR_CMPA_LOW) sh_a[7:0] <= pwdata[7:0];
			if (pstrb[0] && paddr == TOCA_ADDR_CMPA_HIGH) sh_a[15:8] <= pwdata[7:0];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	a_oe_follows_mode: assert property (!$past(reset) && $past(clk_en) && $stable(sh_ctl)
		|-> timer_output_oe == !sh_ctl[6]) else $error("pin enable wrong for mode");
	a_timer_pin_quiet: assert property (!$past(reset) && $stable(sh_ctl) && sh_ctl[7:6] == 2'b11
		|-> !timer_output_pin) else $error("pin active in timer mode");
	a_start_level_set: assert property ($rose(sh_ctl[8]) && sh_ctl[7:6] == 2'b00 && clk_en
		|-> ##[1:2] timer_output_pin == (sh_ctl[3] ^ sh_ctl[2])) else $error("initial level wrong");
	a_pwm_forced_lvl: assert property (!$past(reset) && clk_en && $past(clk_en) && $stable(sh_ctl)
		&& sh_ctl[8] && sh_ctl[7:6] == 2'b10 && !sh_ctl[5]
		|-> timer_output_pin == ((sh_ctl[4] ? sh_ctl[3] : !sh_ctl[3]) ^ sh_ctl[2]))
		else $error("forced pwm level wrong");
	a_cnt_ro_quiet: assert property (acc && (paddr == TOCA_ADDR_CNT_LOW || paddr == TOCA_ADDR_CNT_HIGH)
		|-> pready && !pslverr) else $error("counter access refused");
	a_unmapped_err: assert property (acc && paddr > TOCA_ADDR_CMPP |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_cmpa_low_read: assert property (acc && !pwrite && paddr == TOCA_ADDR_CMPA_LOW
		|-> prdata == {24'h000000, sh_a[7:0]}) else $error("compare a low read wrong");
	a_cmpa_high_read: assert property (acc && !pwrite && paddr == TOCA_ADDR_CMPA_HIGH
		|-> prdata == {24'h000000, sh_a[15:8]}) else $error("compare a high read wrong");
endmodule : toca_top_props
bind toca_top toca_top_props u_props (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe));

// ==== test/toca_top_tb.sv ====
`timescale 1ns/1ps
module toca_top_tb;
	import toca_pkg::*;
	logic        clk_sys, reset, clk_en, psel, penable, pwrite, pready, pslverr, pin, oe, line;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic        err;
	int          n_mismatch = 0;
	int          n_tests = 0;
	toca_top DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_output_pin(pin), .timer_output_oe(oe));
	toca_pin_load u_load (.pin(pin), .oe(oe), .line_level(line));
	// compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task automatic apb(input int w, input int a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= 1'(w);
		paddr <= 12'(a);
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) n_mismatch++;
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ctl(input int r, m, f, l, p, s, c);
		return {23'h0, 1'(r), 2'(m), 2'(f), 1'(l), 1'(p), 1'(s), 1'(c)};
	endfunction : ctl
	// control, counter and compare a come up zero; counter ignores writes
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			apb(0, 12'(i * 4), 0);
			check(rdat, 0);
		end
		apb(1, TOCA_ADDR_CMPA_LOW, 32'hAB);
		apb(1, TOCA_ADDR_CMPA_HIGH, 32'h12);
		apb(1, TOCA_ADDR_CNT_LOW, 32'hFF);
		apb(1, TOCA_ADDR_CNT_HIGH, 32'hFF);
		apb(0, TOCA_ADDR_CMPA_LOW, 0);
		check(rdat, 32'hAB);
		apb(0, TOCA_ADDR_CMPA_HIGH, 0);
		check(rdat, 32'h12);
		apb(0, TOCA_ADDR_CNT_HIGH, 0);
		check(rdat, 0);
		check(err, 0);
		apb(0, 12'h100, 0);
		check(err, 1);
	endtask : t_regs
	// level and polarity in every mode that drives the pin
	task automatic t_levels();
		logic l, p, f;
		apb(1, TOCA_ADDR_CMPA_HIGH, 32'h80);
		for (int i = 0; i < 8; i++) begin
			{l, p, f} = 3'(i);
			apb(1, 0, ctl(0, TOCA_MODE_COMPARE, 0, l, p, 0, 0));
			apb(1, 0, ctl(1, TOCA_MODE_COMPARE, 0, l, p, 0, 0));
			repeat (4) @(posedge clk_sys);
			check(line, l ^ p);
			apb(1, 0, ctl(0, TOCA_MODE_PWM, {1'b0, f}, l, p, 0, 0));
			apb(1, 0, ctl(1, TOCA_MODE_PWM, {1'b0, f}, l, p, 0, 0));
			repeat (4) @(posedge clk_sys);
			check(line, (f ? l : !l) ^ p);
			apb(1, 0, ctl(1, TOCA_MODE_TIMER, 0, l, p, 0, 0));
			repeat (4) @(posedge clk_sys);
			check({oe, pin}, 0);
		end
	endtask : t_levels
	// toggle on a match only; the p match in between leaves the pin alone
	task automatic t_toggle();
		apb(1, TOCA_ADDR_CMPA_HIGH, 0);
		apb(1, TOCA_ADDR_CMPA_LOW, 32'h40);
		apb(1, TOCA_ADDR_CMPP, 1);
		apb(1, 0, ctl(0, TOCA_MODE_COMPARE, TOCA_CMP_TOGGLE, 0, 0, 0, 0));
		apb(1, 0, ctl(1, TOCA_MODE_COMPARE, TOCA_CMP_TOGGLE, 0, 0, 0, 0));
		repeat (32) @(posedge clk_sys);
		check(line, 0);
		repeat (64) @(posedge clk_sys);
		check(line, 1);
		repeat (192) @(posedge clk_sys);
		check(line, 1);
		repeat (64) @(posedge clk_sys);
		check(line, 0);
	endtask : t_toggle
	// run with a setup and record the highest low byte reached
	task automatic t_clear(input logic [31:0] c, input logic [15:0] a, input logic [31:0] exp_lo);
		logic [31:0] top;
		top = 0;
		apb(1, 0, c);
		apb(1, TOCA_ADDR_CMPA_LOW, {24'h0, a[7:0]});
		apb(1, TOCA_ADDR_CMPA_HIGH, {24'h0, a[15:8]});
		apb(1, TOCA_ADDR_CMPP, 1);
		apb(1, 0, c | 32'h100);
		repeat (300) begin
			apb(0, TOCA_ADDR_CNT_LOW, 0);
			if (rdat > top) top = rdat;
		end
		check(top, exp_lo);
		apb(0, TOCA_ADDR_CNT_HIGH, 0);
		check(rdat, 0);
	endtask : t_clear
	// with p at zero the counter spans the full range, then wraps
	task automatic t_overflow();
		apb(1, 0, ctl(0, TOCA_MODE_TIMER, 0, 0, 0, 0, 0));
		apb(1, TOCA_ADDR_CMPP, 0);
		apb(1, 0, ctl(1, TOCA_MODE_TIMER, 0, 0, 0, 0, 0));
		repeat (65400) @(posedge clk_sys);
		apb(0, TOCA_ADDR_CNT_HIGH, 0);
		check(rdat, 32'hFF);
		repeat (200) @(posedge clk_sys);
		apb(0, TOCA_ADDR_CNT_HIGH, 0);
		check(rdat, 0);
	endtask : t_overflow
	// verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	// main sequence
	initial begin
		{reset, clk_en, pstrb} = 6'h3F;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		t_regs();
		t_levels();
		t_toggle();
		t_clear(ctl(0, TOCA_MODE_TIMER, 0, 0, 0, 0, 1), 16'h10, 32'h10);
		t_clear(ctl(0, TOCA_MODE_TIMER, 0, 0, 0, 0, 0), 16'h10, 32'hFF);
		t_clear(ctl(0, TOCA_MODE_COMPARE, 0, 0, 0, 0, 1), 16'h21, 32'h21);
		t_clear(ctl(0, TOCA_MODE_PWM, 2, 0, 0, 0, 1), 16'h10, 32'hFF);
		t_clear(ctl(0, TOCA_MODE_PWM, 2, 0, 0, 1, 0), 16'h30, 32'h30);
		t_overflow();
		finish_test();
	end
	// watchdog sized well past the longest expected run
	initial begin
		#720000;
		n_mismatch++;
		finish_test();
	end
endmodule : toca_top_tb
